// file: core/srw_window_cal.v
// sysref windowing detector, capture tap select and automatic aperture-delay calibration
//
// Function
// - sysref is captured on a deterministic, repeatable device-clock edge every power-on.
// - single-channel mode samples on both clock edges, doubling the sysref window.
// - each capture tap flags 1 when at risk of setup/hold violation, else 0.
// - phase flags are meaningful only after three sysref rising edges are seen.
// - twenty-four taps, smallest to largest delay, reported as a 24-bit vector.
// - flag bits 0 and 23 always read as 1.
// - tap select holds a decimal tap index; only taps 0 to 15 are selectable.
// - sysref is sampled by the delayed clock copy at the selected tap.
// - fine-step bit 0 gives coarse tap spacing, 1 gives fine spacing.
// - search aperture delay until internal clock falling edge meets sysref rising edge.
// - completion flag rises in calibration status when the search finishes.
// - the found aperture-delay setting is readable in the calibration result.
// - calibrated delay stays in use until software disables calibration.
// - search coarse delays with clock plain and inverted; keep smallest working coarse.
// - clock invert adds half a clock period, independent of coarse and fine.
`timescale 1ns/100ps
`include "srw_map.vh"

module srw_window_cal #(
    parameter NUM_TAPS = `SRW_NUM_TAPS
) (
    input wire clk,
    input wire reset,
    input wire [`SRW_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_q,
    input wire single_channel_mode,
    input wire [NUM_TAPS-1:0] tap_samples,
    input wire phase_late,
    output reg sysref_capture_q,
    output reg dual_edge_q,
    output reg fine_step_q,
    output reg [3:0] tap_select_q,
    output reg clock_invert_q,
    output reg [7:0] coarse_delay_q,
    output reg [7:0] fine_delay_q
);
    // search states
    localparam S_IDLE = 3'd0;
    localparam S_APPLY = 3'd1;
    localparam S_SETTLE = 3'd2;
    localparam S_CHECK = 3'd3;
    localparam S_DONE = 3'd4;

    reg [3:0] sel_q;
    reg fine_q;
    reg cal_en_q;
    reg cal_en_prev_q;
    reg [7:0] cal_cfg_q;
    reg [7:0] sw_coarse_q;
    reg [7:0] sw_fine_q;
    reg sw_inv_q;
    reg [2:0] state_q;
    reg try_inv_q;
    reg [7:0] try_coarse_q;
    reg [7:0] wait_q;
    reg found_q;
    reg best_inv_q;
    reg [7:0] best_coarse_q;
    reg done_q;
    reg busy_q;
    reg restart_q;
    wire [NUM_TAPS-1:0] flags;
    wire flags_valid;
    reg [7:0] rd_d;

    function wr_hit;
        input [`SRW_ADDR_W-1:0] a;
        begin
            wr_hit = reg_wr && (reg_addr == a);
        end
    endfunction

    srw_tap_detect #(
        .NUM_TAPS(NUM_TAPS)
    ) srw_tap_detect_inst (
        .clk(clk),
        .reset(reset),
        .restart(restart_q),
        .tap_samples(tap_samples),
        .risk_q(flags),
        .valid_q(flags_valid)
    );

    // software registers; tap select is only 4 bits wide so taps above 15 cannot be chosen
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sel_q <= 4'h0;
            fine_q <= 1'b0;
            cal_en_q <= 1'b0;
            cal_cfg_q <= `SRW_CAL_CONFIG_RST;
            sw_coarse_q <= `SRW_TAD_RST;
            sw_fine_q <= `SRW_TAD_RST;
            sw_inv_q <= 1'b0;
            restart_q <= 1'b1;
        end else begin
            // a tap-spacing change invalidates previous flags
            restart_q <= wr_hit(`SRW_OFS_CLK_CTRL0) && (reg_wdata[`SRW_FINE_STEP_BIT] != fine_q);
            if (wr_hit(`SRW_OFS_CLK_CTRL0)) begin
                sel_q <= reg_wdata[`SRW_SEL_MSB:0];
                fine_q <= reg_wdata[`SRW_FINE_STEP_BIT];
            end
            if (wr_hit(`SRW_OFS_CAL_ENABLE)) begin
                cal_en_q <= reg_wdata[0];
            end
            if (wr_hit(`SRW_OFS_CAL_CONFIG)) begin
                cal_cfg_q <= reg_wdata;
            end
            if (wr_hit(`SRW_OFS_COARSE_DELAY)) begin
                sw_coarse_q <= reg_wdata;
            end
            if (wr_hit(`SRW_OFS_FINE_DELAY)) begin
                sw_fine_q <= reg_wdata;
            end
            if (wr_hit(`SRW_OFS_CLOCK_INVERT)) begin
                sw_inv_q <= reg_wdata[0];
            end
        end
    end

    // aperture-delay search: plain clock first, then inverted, each coarse upward from 0
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= S_IDLE;
            try_inv_q <= 1'b0;
            try_coarse_q <= 8'h00;
            wait_q <= 8'h00;
            found_q <= 1'b0;
            best_inv_q <= 1'b0;
            best_coarse_q <= 8'h00;
            done_q <= 1'b0;
            busy_q <= 1'b0;
            cal_en_prev_q <= 1'b0;
        end else if (!cal_en_q) begin
            state_q <= S_IDLE; // result kept readable, delay returns to software
            busy_q <= 1'b0;
            cal_en_prev_q <= 1'b0;
        end else begin
            cal_en_prev_q <= 1'b1;
            case (state_q)
                S_IDLE: begin
                    // a fresh enable restarts the search even after a finished one
                    if (!done_q || !cal_en_prev_q) begin
                        done_q <= 1'b0;
                        busy_q <= 1'b1;
                        found_q <= 1'b0;
                        try_inv_q <= 1'b0;
                        try_coarse_q <= 8'h00;
                        state_q <= S_APPLY;
                    end
                end
                S_APPLY: begin
                    wait_q <= cal_cfg_q; // settle time lets the delay line and sysref sampling catch up
                    state_q <= S_SETTLE;
                end
                S_SETTLE: begin
                    if (wait_q == 8'h00) begin
                        state_q <= S_CHECK;
                    end else begin
                        wait_q <= wait_q - 8'h01;
                    end
                end
                S_CHECK: begin
                    // falling edge reached the sysref rising edge at this setting
                    if (phase_late && (!found_q || try_coarse_q < best_coarse_q)) begin
                        found_q <= 1'b1;
                        best_inv_q <= try_inv_q;
                        best_coarse_q <= try_coarse_q;
                    end
                    if (phase_late || try_coarse_q == `SRW_COARSE_LAST ||
                        (found_q && try_coarse_q >= best_coarse_q)) begin
                        if (try_inv_q) begin
                            state_q <= S_DONE;
                        end else begin
                            try_inv_q <= 1'b1;
                            try_coarse_q <= 8'h00;
                            state_q <= S_APPLY;
                        end
                    end else begin
                        try_coarse_q <= try_coarse_q + 8'h01;
                        state_q <= S_APPLY;
                    end
                end
                S_DONE: begin
                    done_q <= 1'b1;
                    busy_q <= 1'b0;
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // delay outputs: search trial, calibrated result, or software fields
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            clock_invert_q <= 1'b0;
            coarse_delay_q <= 8'h00;
            fine_delay_q <= 8'h00;
            sysref_capture_q <= 1'b0;
            dual_edge_q <= 1'b0;
            fine_step_q <= 1'b0;
            tap_select_q <= 4'h0;
        end else begin
            fine_delay_q <= sw_fine_q;
            if (cal_en_q && busy_q) begin
                clock_invert_q <= try_inv_q;
                coarse_delay_q <= try_coarse_q;
            end else if (cal_en_q && done_q) begin
                clock_invert_q <= best_inv_q;
                coarse_delay_q <= best_coarse_q;
            end else begin
                clock_invert_q <= sw_inv_q;
                coarse_delay_q <= sw_coarse_q;
            end
            sysref_capture_q <= tap_samples[sel_q];
            dual_edge_q <= single_channel_mode;
            fine_step_q <= fine_q;
            tap_select_q <= sel_q;
        end
    end

    // read mux; unmapped addresses read as zero
    always @* begin
        rd_d = 8'h00;
        case (reg_addr)
            `SRW_OFS_CLK_CTRL0: rd_d = {3'h0, fine_q, sel_q};
            `SRW_OFS_FLAGS_LOW: rd_d = flags[7:0];
            `SRW_OFS_FLAGS_MID: rd_d = flags[15:8];
            `SRW_OFS_FLAGS_HIGH: rd_d = flags[23:16];
            `SRW_OFS_CAL_ENABLE: rd_d = {7'h00, cal_en_q};
            `SRW_OFS_CAL_CONFIG: rd_d = cal_cfg_q;
            `SRW_OFS_CAL_STATUS: rd_d = {5'h00, flags_valid, busy_q, done_q};
            `SRW_OFS_CAL_RES_COARSE: rd_d = best_coarse_q;
            `SRW_OFS_CAL_RES_INV: rd_d = {7'h00, best_inv_q};
            `SRW_OFS_COARSE_DELAY: rd_d = sw_coarse_q;
            `SRW_OFS_FINE_DELAY: rd_d = sw_fine_q;
            `SRW_OFS_CLOCK_INVERT: rd_d = {7'h00, sw_inv_q};
            default: rd_d = 8'h00;
        endcase
    end

    // read data registered; it holds until the next read
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_d;
        end
    end
endmodule

// file: core/srw_map.vh
// register offsets, field positions and reset values of the sysref window and calibration block
`ifndef SRW_MAP_VH
`define SRW_MAP_VH

// register addresses
`define SRW_ADDR_W 12
`define SRW_OFS_CLK_CTRL0 12'h029
`define SRW_OFS_FLAGS_LOW 12'h02C
`define SRW_OFS_FLAGS_MID 12'h02D
`define SRW_OFS_FLAGS_HIGH 12'h02E
`define SRW_OFS_CAL_ENABLE 12'h0B0
`define SRW_OFS_CAL_CONFIG 12'h0B1
`define SRW_OFS_CAL_STATUS 12'h0B4
`define SRW_OFS_CAL_RES_COARSE 12'h0B5
`define SRW_OFS_CAL_RES_INV 12'h0B6
`define SRW_OFS_COARSE_DELAY 12'h0B8
`define SRW_OFS_FINE_DELAY 12'h0B9
`define SRW_OFS_CLOCK_INVERT 12'h0BA

// field positions
`define SRW_SEL_MSB 3
`define SRW_FINE_STEP_BIT 4
`define SRW_DONE_BIT 0
`define SRW_BUSY_BIT 1

// reset values
`define SRW_CLK_CTRL0_RST 8'h00
`define SRW_CAL_CONFIG_RST 8'h10
`define SRW_TAD_RST 8'h00

// detector and search constants
`define SRW_NUM_TAPS 24
`define SRW_SEL_TAPS 16
`define SRW_EDGES_VALID 2'h3
`define SRW_COARSE_LAST 8'hFF

`endif

// file: core/srw_tap_detect.v
// per-tap setup/hold risk detector for the sysref capture window
`timescale 1ns/100ps
`include "srw_map.vh"

module srw_tap_detect #(
    parameter NUM_TAPS = `SRW_NUM_TAPS
) (
    input wire clk,
    input wire reset,
    input wire restart,
    input wire [NUM_TAPS-1:0] tap_samples,
    output reg [NUM_TAPS-1:0] risk_q,
    output reg valid_q
);
    reg [1:0] edge_cnt_q;
    reg tap0_prev_q;
    wire [NUM_TAPS-1:0] risk_now;
    genvar i;

    // an inner tap is risky when sysref changes between it and a neighbour
    assign risk_now[0] = 1'b1;
    assign risk_now[NUM_TAPS-1] = 1'b1;
    generate
        for (i = 1; i < NUM_TAPS - 1; i = i + 1) begin : g_tap
            assign risk_now[i] = (tap_samples[i] ^ tap_samples[i-1]) | (tap_samples[i] ^ tap_samples[i+1]);
        end
    endgenerate

    // risk is sticky so a slow-moving edge is never missed between sysref periods
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            risk_q <= {NUM_TAPS{1'b1}};
            edge_cnt_q <= 2'h0;
            tap0_prev_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            tap0_prev_q <= tap_samples[0];
            if (restart) begin
                // edge taps stay set, and a risk seen in the restart cycle still counts
                risk_q <= risk_now;
                edge_cnt_q <= 2'h0;
                valid_q <= 1'b0;
            end else begin
                risk_q <= risk_q | risk_now;
                if (tap_samples[0] && !tap0_prev_q && edge_cnt_q != `SRW_EDGES_VALID) begin
                    edge_cnt_q <= edge_cnt_q + 2'h1;
                end
                valid_q <= (edge_cnt_q == `SRW_EDGES_VALID);
            end
        end
    end
endmodule

// file: tb/srw_clkgen.sv
// far-side model: periodic sysref seen through the capture taps, plus a phase detector
`timescale 1ns/100ps
module srw_clkgen #(parameter PERIOD = 12) (
    input wire clk,
    input wire [4:0] edge_tap,
    input wire [7:0] late_plain,
    input wire [7:0] late_inv,
    input wire clock_invert_q,
    input wire [7:0] coarse_delay_q,
    output wire [23:0] tap_samples,
    output wire phase_late
);
    reg [7:0] cnt_q = 8'h00;
    reg ref_q = 1'b0;
    reg ref_old_q = 1'b0;
    wire [23:0] early = (24'h000001 << edge_tap) - 24'h000001;
    // sysref never stops, so a search always sees fresh edges
    always @(posedge clk) begin
        cnt_q <= (cnt_q == PERIOD - 1) ? 8'h00 : cnt_q + 8'h01;
        ref_q <= (cnt_q < PERIOD / 2);
        ref_old_q <= ref_q;
    end
    // taps from the edge position on see sysref one clock late
    assign tap_samples = ({24{ref_q}} & early) | ({24{ref_old_q}} & ~early);
    // half-period shift of the inverted clock gives it its own threshold
    assign phase_late = clock_invert_q ? (coarse_delay_q >= late_inv) : (coarse_delay_q >= late_plain);
endmodule

// file: tb/srw_window_cal_asserts.sv
// port-level assertions for the sysref window and calibration block
`timescale 1ns/100ps
module srw_wc_asserts #(parameter NUM_TAPS = 24) (
    input wire clk,
    input wire reset,
    input wire [11:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_q,
    input wire single_channel_mode,
    input wire [NUM_TAPS-1:0] tap_samples,
    input wire phase_late,
    input wire sysref_capture_q,
    input wire dual_edge_q,
    input wire fine_step_q,
    input wire [3:0] tap_select_q,
    input wire clock_invert_q,
    input wire [7:0] coarse_delay_q,
    input wire [7:0] fine_delay_q
);
    reg en_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // shadow of the enable bit: a restart is only expected from idle
    always @(posedge clk or posedge reset)
        if (reset)
            en_q <= 1'b0;
        else if (reg_wr && reg_addr == 12'h0B0)
            en_q <= reg_wdata[0];
    sequence s_cal_start; reg_wr && reg_addr == 12'h0B0 && reg_wdata[0] && !en_q; endsequence
    sequence s_trial0; coarse_delay_q == 8'h00 && !clock_invert_q; endsequence
    property p_dual; $stable(single_channel_mode) |=> dual_edge_q == $past(single_channel_mode); endproperty
    a_dual: assert property (p_dual) else $error("dual edge lags mode");
    property p_capture;
        !$past(reset) && $stable(tap_samples) && $stable(tap_select_q) |-> sysref_capture_q == tap_samples[tap_select_q];
    endproperty
    a_capture: assert property (p_capture) else $error("capture tap wrong");
    property p_sel; reg_wr && reg_addr == 12'h029 |-> ##3 tap_select_q == $past(reg_wdata[3:0], 3); endproperty
    a_sel: assert property (p_sel) else $error("tap select wrong");
    property p_fine; reg_wr && reg_addr == 12'h029 |-> ##3 fine_step_q == $past(reg_wdata[4], 3); endproperty
    a_fine: assert property (p_fine) else $error("fine step wrong");
    property p_edge_lo; reg_rd && reg_addr == 12'h02C |=> reg_rdata_q[0]; endproperty
    a_edge_lo: assert property (p_edge_lo) else $error("flag 0 low");
    property p_cal_start; s_cal_start |-> ##[3:6] s_trial0; endproperty
    a_cal_start: assert property (p_cal_start) else $error("search not from zero");
    property p_sw_coarse; reg_wr && reg_addr == 12'h0B8 && !en_q |-> ##3 coarse_delay_q == $past(reg_wdata, 3); endproperty
    a_sw_coarse: assert property (p_sw_coarse) else $error("coarse not from field");
    property p_sw_fine; reg_wr && reg_addr == 12'h0B9 |-> ##3 fine_delay_q == $past(reg_wdata, 3); endproperty
    a_sw_fine: assert property (p_sw_fine) else $error("fine not from field");
endmodule

// file: tb/srw_window_cal_tb.sv
// self-checking bench for the sysref window and calibration block
`timescale 1ns/100ps
module srw_window_cal_tb;
    reg clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, single_channel_mode = 1'b0;
    reg [11:0] reg_addr = 12'h000;
    reg [7:0] reg_wdata = 8'h00, late_plain = 8'h0A, late_inv = 8'h04, rv;
    reg [4:0] edge_tap = 5'h09;
    reg [23:0] flags;
    reg cap;
    wire [23:0] tap_samples;
    wire [7:0] reg_rdata_q, coarse_delay_q, fine_delay_q;
    wire [3:0] tap_select_q;
    wire phase_late, sysref_capture_q, dual_edge_q, fine_step_q, clock_invert_q;
    integer err_count = 0, total_checks = 0;
    always #2 clk = ~clk;
    srw_window_cal srw_window_cal_inst (
        .clk(clk),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q),
        .single_channel_mode(single_channel_mode),
        .tap_samples(tap_samples),
        .phase_late(phase_late),
        .sysref_capture_q(sysref_capture_q),
        .dual_edge_q(dual_edge_q),
        .fine_step_q(fine_step_q),
        .tap_select_q(tap_select_q),
        .clock_invert_q(clock_invert_q),
        .coarse_delay_q(coarse_delay_q),
        .fine_delay_q(fine_delay_q)
    );
    srw_clkgen srw_clkgen_inst (
        .clk(clk),
        .edge_tap(edge_tap),
        .late_plain(late_plain),
        .late_inv(late_inv),
        .clock_invert_q(clock_invert_q),
        .coarse_delay_q(coarse_delay_q),
        .tap_samples(tap_samples),
        .phase_late(phase_late)
    );
    task chk(input [23:0] seen, input [23:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // strobes rise and fall on falling edges, so each is seen at one rising edge
    task wr(input [11:0] a, input [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task rd(input [11:0] a);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        rv = reg_rdata_q;
    endtask
    // bounded poll; a hang ends the run as a mismatch
    task wait_bit(input [11:0] a, input integer b);
        rv = 8'h00;
        for (int n = 0; rv[b] !== 1'b1; n++) begin
            if (n == 300) begin
                chk(24'h000001, 24'h000000);
                report_and_stop;
            end else begin
                rd(a);
            end
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task t_window;
        rd(12'h0B4);
        chk(rv[2], 1'b0);
        rd(12'h3FF);
        chk(rv, 8'h00);
        wr(12'h029, 8'h10);
        wait_bit(12'h0B4, 2);
        // three sysref periods so every boundary has toggled
        repeat (36) @(negedge clk);
        rd(12'h02C);
        flags[7:0] = rv;
        rd(12'h02D);
        flags[15:8] = rv;
        rd(12'h02E);
        flags[23:16] = rv;
        chk(flags, 24'h800301);
        $display("window test done");
    endtask
    task t_select;
        wr(12'h029, 8'h0F);
        single_channel_mode = 1'b1;
        repeat (2) @(negedge clk);
        chk(tap_select_q, 4'hF);
        chk(fine_step_q, 1'b0);
        chk(dual_edge_q, 1'b1);
        // capture follows the selected tap one clock late
        repeat (12) begin
            cap = tap_samples[15];
            @(negedge clk);
            chk(sysref_capture_q, cap);
        end
        $display("select test done");
    endtask
    task t_cal(input [7:0] lp, input [7:0] li, input ei, input [7:0] ec);
        late_plain = lp;
        late_inv = li;
        wr(12'h029, 8'h10);
        wr(12'h0B1, 8'h02);
        wr(12'h0B0, 8'h01);
        rd(12'h0B4);
        chk(rv[1:0], 2'h2);
        wait_bit(12'h0B4, 0);
        rd(12'h0B5);
        chk(rv, ec);
        rd(12'h0B6);
        chk(rv[0], ei);
        repeat (40) @(negedge clk);
        chk({clock_invert_q, coarse_delay_q}, {ei, ec});
        wr(12'h0B0, 8'h00);
        $display("calibration test done");
    endtask
    task t_sw;
        wr(12'h0B8, 8'h5A);
        wr(12'h0B9, 8'h33);
        wr(12'h0BA, 8'h01);
        repeat (2) @(negedge clk);
        chk({clock_invert_q, coarse_delay_q, fine_delay_q}, {1'b1, 8'h5A, 8'h33});
        $display("software delay test done");
    endtask
    initial begin
        repeat (8) @(negedge clk);
        reset = 1'b0;
        t_window;
        t_select;
        t_cal(8'h0A, 8'h04, 1'b1, 8'h04);
        t_cal(8'h03, 8'h03, 1'b0, 8'h03);
        t_sw;
        report_and_stop;
    end
endmodule
bind srw_window_cal srw_wc_asserts #(.NUM_TAPS(NUM_TAPS)) srw_wc_asserts_inst (
    .clk(clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q),
    .single_channel_mode(single_channel_mode),
    .tap_samples(tap_samples),
    .phase_late(phase_late),
    .sysref_capture_q(sysref_capture_q),
    .dual_edge_q(dual_edge_q),
    .fine_step_q(fine_step_q),
    .tap_select_q(tap_select_q),
    .clock_invert_q(clock_invert_q),
    .coarse_delay_q(coarse_delay_q),
    .fine_delay_q(fine_delay_q)
);
